// ### design/ssc_pkg.sv
// Constants, types and carriers for the service and queue statistics block.
// Assumes one core clock; all users import the whole package.
//
// Notes on behaviour
// R1: Six service counter types, each set to count bytes or frames.
// R2: One event mask per service type, shared by every service entry.
// R3: One clear control zeroes every service counter at once.
// R4: Global switch picks colour from drop precedence or policer colour.
// R5: Global table maps each drop precedence value to a counting colour.
// R6: Entry index is base plus class offset, or VLAN ID when enabled.
// R7: Mask bits 0, 1, 2 select green, yellow and red traffic.
// R8: Mask bits 3, 4, 5 select unicast, multicast and flooded traffic.
// R9: Types 0 to 2 are 40-bit counters; 3 to 5 are 32-bit.
// R10: Low word for all six types; high byte only for types 0 to 2.
// R11: Low-word read latches the high byte into a shadow for the next read.
// R12: Software reads low word first, then high byte straight after.
// R13: Software writes high byte first, then the low word.
// R14: Queue number equals port times eight plus internal priority.
// R15: Two queue counter types, each set to count bytes or frames.
// R16: Queue events are policer-passed traffic and policer-discarded traffic.
// R17: One event mask per queue type, shared by every queue.
// R18: Queue counters are 40 bits: low word plus high byte.
// R19: Hit when frame events meet the mask; add length or one.
// R20: Counters wrap silently to zero at their full width.
// R21: Software clears the counters before first use.
package ssc_pkg;

  // Counter geometry
  localparam int SVC_TYPES   = 6;
  localparam int SVC_WIDE    = 3;
  localparam int SVC_ENTRIES = 64;
  localparam int Q_TYPES     = 2;
  localparam int Q_PORTS     = 6;
  localparam int Q_PER_PORT  = 8;
  localparam int Q_COUNT     = 48;
  localparam int IDX_W       = 6;
  localparam int CNT_W       = 40;
  localparam int LO_W        = 32;
  localparam int HI_W        = 8;
  localparam int LEN_W       = 14;

  // Register byte addresses
  localparam logic [11:0] ADDR_SVC_CFG0 = 12'h000;
  localparam logic [11:0] ADDR_Q_CFG0   = 12'h020;
  localparam logic [11:0] ADDR_GLOBAL   = 12'h030;
  localparam logic [11:0] ADDR_DP_MAP   = 12'h034;
  localparam logic [11:0] ADDR_SEL      = 12'h040;
  localparam logic [11:0] ADDR_LOW      = 12'h044;
  localparam logic [11:0] ADDR_HIGH     = 12'h048;

  // Field positions and reset values
  localparam int CFG_BYTE_BIT    = 8;
  localparam int GLB_POL_BIT     = 0;
  localparam int GLB_VLAN_BIT    = 1;
  localparam int GLB_CLEAR_BIT   = 8;
  localparam int SEL_QUEUE_BIT   = 15;
  localparam int SEL_TYPE_LSB    = 8;
  localparam logic [7:0] DP_MAP_RST = 8'hA4;

  typedef enum logic [1:0] {COL_GREEN, COL_YELLOW, COL_RED, COL_NONE} ssc_colour_e;
  typedef enum logic [1:0] {CAST_UNI, CAST_MULTI, CAST_FLOOD, CAST_NONE} ssc_cast_e;

  // Per-frame classification from the analyzer pipeline
  typedef struct packed {
    logic [5:0]       service_base_index;
    logic [2:0]       class_offset;
    logic [11:0]      vid;
    logic [1:0]       drop_precedence;
    ssc_colour_e      pol_colour;
    ssc_cast_e        cast;
    logic [LEN_W-1:0] bytes;
    logic [2:0]       port;
    logic [2:0]       iprio;
    logic             qpol_pass;
    logic             qpol_drop;
  } ssc_frame_s;

endpackage

// ### design/ssc_stat_top.sv
// Service and queue statistics counters with an APB register slave.
// Assumes frame results arrive on mclk_i from the analyzer pipeline and
// that software keeps the low/high ordering for 40-bit counters.
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module ssc_stat_top
  import ssc_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        frame_valid_i,
  input  wire ssc_frame_s  frame_i
);

  // Counter storage; types 3..5 keep their top byte at zero
  logic [CNT_W-1:0] svc_cnt_r [SVC_TYPES][SVC_ENTRIES];
  logic [CNT_W-1:0] q_cnt_r   [Q_TYPES][Q_COUNT];

  // Configuration
  logic [5:0]       svc_mask_r [SVC_TYPES];
  logic             svc_byte_r [SVC_TYPES];
  logic [1:0]       q_mask_r   [Q_TYPES];
  logic             q_byte_r   [Q_TYPES];
  logic             pol_src_r;
  logic             vlan_en_r;
  logic [7:0]       dp_map_r;
  logic             sel_q_r;
  logic [2:0]       sel_type_r;
  logic [IDX_W-1:0] sel_idx_r;
  logic [HI_W-1:0]  hi_pend_r;
  logic [HI_W-1:0]  shadow_r;
  logic [CNT_W-1:0] hold_r;
  logic [31:0]      prdata_r;
  logic             pslverr_r;

  // Frame-side decode
  ssc_colour_e      colour_w;
  logic [5:0]       svc_ev_w;
  logic [1:0]       q_ev_w;
  logic [11:0]      svc_full_w;
  logic [IDX_W-1:0] svc_idx_w;
  logic             svc_ok_w;
  logic [IDX_W-1:0] q_idx_w;
  logic             q_ok_w;
  logic [SVC_TYPES-1:0] svc_hit_w;
  logic [CNT_W-1:0]     svc_add_w [SVC_TYPES];
  logic [Q_TYPES-1:0]   q_hit_w;
  logic [CNT_W-1:0]     q_add_w [Q_TYPES];

  // Bus-side decode
  logic             setup_w;
  logic             acc_w;
  logic             acc_wr_w;
  logic             acc_rd_w;
  logic             clr_w;
  logic             sel_ok_w;
  logic             sel_wide_w;
  logic [CNT_W-1:0] rd_val_w;
  logic [CNT_W-1:0] wr_val_w;
  logic             wr_low_w;

  // Colour code or cast code to one-hot event bits; 3 means no event
  function automatic logic [2:0] onehot3(input logic [1:0] code);
    onehot3 = (code == 2'h3) ? 3'h0 : 3'(3'h1 << code);
  endfunction

  // Per-type config word address check
  function automatic logic cfg_hit(input logic [11:0] a, input logic [11:0] base,
                                   input int n);
    cfg_hit = (a >= base) && (a < base + 12'(4 * n)) && (a[1:0] == 2'h0);
  endfunction

  // Narrow service types wrap at 32 bits
  function automatic logic [CNT_W-1:0] svc_wrap(input int t, input logic [CNT_W-1:0] v);
    svc_wrap = (t >= SVC_WIDE) ? {8'h00, v[LO_W-1:0]} : v;
  endfunction

  // Colour source and precedence table
  always_comb begin
    colour_w = pol_src_r ? frame_i.pol_colour :                           // R4
               ssc_colour_e'(dp_map_r[2 * frame_i.drop_precedence +: 2]); // R5
  end

  // Event vectors: cast in bits 5..3, colour in 2..0
  assign svc_ev_w = {onehot3(frame_i.cast), onehot3(colour_w)}; // R7 R8
  assign q_ev_w   = {frame_i.qpol_drop, frame_i.qpol_pass};     // R16

  // Entry index; sums or VIDs beyond the table are not counted
  always_comb begin
    svc_full_w = vlan_en_r ? frame_i.vid :                        // R6
                 12'(frame_i.service_base_index) + 12'(frame_i.class_offset);
    svc_ok_w   = svc_full_w < 12'(SVC_ENTRIES);
    svc_idx_w  = svc_full_w[IDX_W-1:0];
  end

  // Queue number is port*8 + priority, i.e. the two fields side by side
  assign q_idx_w = {frame_i.port, frame_i.iprio}; // R14
  assign q_ok_w  = frame_i.port < 3'(Q_PORTS);

  // Per-type hit and increment
  generate
    for (genvar t = 0; t < SVC_TYPES; t++) begin : g_svc
      assign svc_hit_w[t] = frame_valid_i && svc_ok_w && |(svc_ev_w & svc_mask_r[t]); // R2 R19
      assign svc_add_w[t] = svc_byte_r[t] ? CNT_W'(frame_i.bytes) : 40'h00_0000_0001;  // R1
    end
    for (genvar t = 0; t < Q_TYPES; t++) begin : g_q
      assign q_hit_w[t] = frame_valid_i && q_ok_w && |(q_ev_w & q_mask_r[t]); // R17 R19
      assign q_add_w[t] = q_byte_r[t] ? CNT_W'(frame_i.bytes) : 40'h00_0000_0001; // R15
    end
  endgenerate

  // APB phase decode
  assign setup_w  = psel_i && !penable_i;
  assign acc_w    = psel_i && penable_i;
  assign acc_wr_w = acc_w && pwrite_i;
  assign acc_rd_w = acc_w && !pwrite_i;
  assign clr_w    = acc_wr_w && (paddr_i == ADDR_GLOBAL) && pwdata_i[GLB_CLEAR_BIT]; // R3
  assign wr_low_w = acc_wr_w && (paddr_i == ADDR_LOW) && sel_ok_w;

  // Selected counter: validity, width and current value
  always_comb begin
    sel_ok_w   = sel_q_r ? (sel_type_r < 3'(Q_TYPES)) && (sel_idx_r < 6'(Q_COUNT))
                         : (sel_type_r < 3'(SVC_TYPES));
    sel_wide_w = sel_q_r || (sel_type_r < 3'(SVC_WIDE)); // R10 R18
    rd_val_w   = 40'h00_0000_0000;
    if (sel_ok_w) begin
      if (sel_q_r) begin
        rd_val_w = q_cnt_r[sel_type_r[0]][sel_idx_r];
      end else begin
        rd_val_w = svc_cnt_r[sel_type_r][sel_idx_r];
      end
    end
    wr_val_w = sel_wide_w ? {hi_pend_r, pwdata_i} : {8'h00, pwdata_i}; // R13
  end

  // Service counters; a same-cycle software write beats the frame update
  always_ff @(posedge mclk_i) begin
    if (rst_i || clr_w) begin
      for (int t = 0; t < SVC_TYPES; t++) begin
        for (int e = 0; e < SVC_ENTRIES; e++) begin
          svc_cnt_r[t][e] <= 40'h00_0000_0000; // R3
        end
      end
    end else begin
      for (int t = 0; t < SVC_TYPES; t++) begin
        if (svc_hit_w[t]) begin
          svc_cnt_r[t][svc_idx_w] <= svc_wrap(t, svc_cnt_r[t][svc_idx_w] + svc_add_w[t]); // R9 R20
        end
      end
      if (wr_low_w && !sel_q_r) begin
        svc_cnt_r[sel_type_r][sel_idx_r] <= wr_val_w;
      end
    end
  end

  // Queue counters; the service clear leaves them alone
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      for (int t = 0; t < Q_TYPES; t++) begin
        for (int e = 0; e < Q_COUNT; e++) begin
          q_cnt_r[t][e] <= 40'h00_0000_0000;
        end
      end
    end else begin
      for (int t = 0; t < Q_TYPES; t++) begin
        if (q_hit_w[t]) begin
          q_cnt_r[t][q_idx_w] <= q_cnt_r[t][q_idx_w] + q_add_w[t]; // R18 R20
        end
      end
      if (wr_low_w && sel_q_r) begin
        q_cnt_r[sel_type_r[0]][sel_idx_r] <= wr_val_w;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      for (int t = 0; t < SVC_TYPES; t++) begin
        svc_mask_r[t] <= 6'h00;
        svc_byte_r[t] <= 1'b0;
      end
      for (int t = 0; t < Q_TYPES; t++) begin
        q_mask_r[t] <= 2'h0;
        q_byte_r[t] <= 1'b0;
      end
      pol_src_r  <= 1'b0;
      vlan_en_r  <= 1'b0;
      dp_map_r   <= DP_MAP_RST;
      sel_q_r    <= 1'b0;
      sel_type_r <= 3'h0;
      sel_idx_r  <= 6'h00;
      hi_pend_r  <= 8'h00;
    end else if (acc_wr_w) begin
      if (cfg_hit(paddr_i, ADDR_SVC_CFG0, SVC_TYPES)) begin
        svc_mask_r[paddr_i[4:2]] <= pwdata_i[5:0];            // R2
        svc_byte_r[paddr_i[4:2]] <= pwdata_i[CFG_BYTE_BIT];   // R1
      end
      if (cfg_hit(paddr_i, ADDR_Q_CFG0, Q_TYPES)) begin
        q_mask_r[paddr_i[2]] <= pwdata_i[1:0];                // R17
        q_byte_r[paddr_i[2]] <= pwdata_i[CFG_BYTE_BIT];       // R15
      end
      if (paddr_i == ADDR_GLOBAL) begin
        pol_src_r <= pwdata_i[GLB_POL_BIT];  // R4
        vlan_en_r <= pwdata_i[GLB_VLAN_BIT]; // R6
      end
      if (paddr_i == ADDR_DP_MAP) begin
        dp_map_r <= pwdata_i[7:0]; // R5
      end
      if (paddr_i == ADDR_SEL) begin
        sel_q_r    <= pwdata_i[SEL_QUEUE_BIT];
        sel_type_r <= pwdata_i[SEL_TYPE_LSB +: 3];
        sel_idx_r  <= pwdata_i[IDX_W-1:0];
      end
      if (paddr_i == ADDR_HIGH) begin
        hi_pend_r <= pwdata_i[HI_W-1:0]; // R13
      end
    end
  end

  // Read data, error and counter snapshot taken in the setup cycle,
  // so low word and shadow byte come from the same counter value
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
      hold_r    <= 40'h00_0000_0000;
    end else if (setup_w) begin
      hold_r    <= sel_wide_w ? rd_val_w : 40'h00_0000_0000;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      if (cfg_hit(paddr_i, ADDR_SVC_CFG0, SVC_TYPES)) begin
        prdata_r <= {23'h000000, svc_byte_r[paddr_i[4:2]], 2'h0, svc_mask_r[paddr_i[4:2]]};
      end else if (cfg_hit(paddr_i, ADDR_Q_CFG0, Q_TYPES)) begin
        prdata_r <= {23'h000000, q_byte_r[paddr_i[2]], 6'h00, q_mask_r[paddr_i[2]]};
      end else if (paddr_i == ADDR_GLOBAL) begin
        prdata_r <= {30'h0000_0000, vlan_en_r, pol_src_r};
      end else if (paddr_i == ADDR_DP_MAP) begin
        prdata_r <= {24'h00_0000, dp_map_r};
      end else if (paddr_i == ADDR_SEL) begin
        prdata_r <= {16'h0000, sel_q_r, 4'h0, sel_type_r, 2'h0, sel_idx_r};
      end else if (paddr_i == ADDR_LOW) begin
        prdata_r <= rd_val_w[LO_W-1:0]; // R10
      end else if (paddr_i == ADDR_HIGH) begin
        prdata_r <= {24'h00_0000, shadow_r}; // R11
      end else begin
        pslverr_r <= 1'b1;
      end
    end
  end

  // Shadow byte loads on the accepted low-word read
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      shadow_r <= 8'h00;
    end else if (acc_rd_w && (paddr_i == ADDR_LOW)) begin
      shadow_r <= hold_r[CNT_W-1:LO_W]; // R11
    end
  end

  // Zero-wait slave: data is ready from the setup snapshot
  assign pready_o  = 1'b1;
  assign prdata_o  = prdata_r;
  assign pslverr_o = pslverr_r && acc_w;

  // ---------------------------------------------------------------
  // Assertions
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  logic [CNT_W-1:0] svc0_old_w;
  logic [CNT_W-1:0] svc3_old_w;
  logic [CNT_W-1:0] q1_old_w;
  assign svc0_old_w = svc_cnt_r[0][svc_idx_w];
  assign svc3_old_w = svc_cnt_r[3][svc_idx_w];
  assign q1_old_w   = q_cnt_r[1][q_idx_w];

  sequence low_read_s;
    acc_rd_w && (paddr_i == ADDR_LOW) && sel_ok_w && sel_wide_w;
  endsequence

  sequence high_setup_s;
    setup_w && (paddr_i == ADDR_HIGH);
  endsequence

  sequence quiet_bus_s;
    !wr_low_w && !clr_w;
  endsequence

  svc_clear_a: assert property (clr_w |=> (svc_cnt_r[0][0] == 40'h00_0000_0000) // R3
      && (svc_cnt_r[5][SVC_ENTRIES-1] == 40'h00_0000_0000))
    else $error("service clear left a counter non-zero");

  shadow_pair_a: assert property (low_read_s ##1 high_setup_s // R11
      |=> prdata_o == {24'h00_0000, $past(hold_r[CNT_W-1:LO_W], 2)})
    else $error("high byte read does not match the latched shadow");

  // Same pairing with one idle bus cycle between the two reads
  shadow_gap_a: assert property (low_read_s ##1 !psel_i ##1 high_setup_s // R11
      |=> prdata_o == {24'h00_0000, $past(hold_r[CNT_W-1:LO_W], 3)})
    else $error("high byte read after a gap does not match the shadow");

  byte_count_a: assert property ((svc_hit_w[0] && svc_byte_r[0]) and quiet_bus_s // R19
      |=> svc_cnt_r[0][$past(svc_idx_w)] == $past(svc0_old_w) + CNT_W'($past(frame_i.bytes)))
    else $error("byte mode type 0 did not add the frame length");

  frame_wrap_a: assert property ((svc_hit_w[3] && !svc_byte_r[3]) and quiet_bus_s // R9
      |=> svc_cnt_r[3][$past(svc_idx_w)] == {8'h00, $past(svc3_old_w[LO_W-1:0]) + 32'h0000_0001})
    else $error("frame type 3 did not count by one within 32 bits");

  mask_hold_a: assert property ((frame_valid_i && !svc_hit_w[0]) and quiet_bus_s // R2
      |=> svc_cnt_r[0][$past(svc_idx_w)] == $past(svc0_old_w))
    else $error("type 0 counted without a mask match");

  colour_bits_a: assert property (frame_valid_i && !pol_src_r && (frame_i.cast == CAST_NONE) // R7
      && (dp_map_r[2 * frame_i.drop_precedence +: 2] == 2'h1) |-> svc_ev_w == 6'h02)
    else $error("yellow from the precedence table did not raise event bit 1");

  cast_bits_a: assert property (frame_valid_i && pol_src_r && (frame_i.pol_colour == COL_NONE) // R8
      && (frame_i.cast == CAST_FLOOD) |-> svc_ev_w == 6'h20)
    else $error("flooded frame did not raise event bit 5");

  vlan_index_a: assert property (frame_valid_i && vlan_en_r && (frame_i.vid < 12'h040) // R6
      |-> svc_ok_w && (svc_idx_w == frame_i.vid[IDX_W-1:0]))
    else $error("VLAN indexing did not use the frame VID");

  queue_drop_a: assert property (frame_valid_i && (frame_i.port == 3'h2) && frame_i.qpol_drop // R16
      && q_mask_r[1][1] && !q_byte_r[1] and quiet_bus_s
      |=> q_cnt_r[1][$past(q_idx_w)] == $past(q1_old_w) + 40'h00_0000_0001
          && $past(q_idx_w) == 6'(16 + $past(frame_i.iprio)))
    else $error("queue drop event not counted at port*8+prio");

endmodule

`default_nettype wire

// ### dv/ssc_frame_src.sv
// Behavioural model of the analyzer pipeline that hands frame results on.
// Assumes the bench calls send() from one process at a time.
`timescale 1ns/1ps
`default_nettype none

module ssc_frame_src
  import ssc_pkg::*;
(
  input  wire logic       mclk_i,
  output logic            frame_valid_o,
  output ssc_frame_s      frame_o
);
  // Idle fields are junk, so the block must qualify them with the pulse
  initial begin
    frame_valid_o = 1'b0;
    frame_o       = '0;
  end

  // One frame, one cycle pulse, fields inverted once it is gone
  task automatic send(input ssc_frame_s f);
    @(posedge mclk_i);
    frame_valid_o <= 1'b1;
    frame_o       <= f;
    @(posedge mclk_i);
    frame_valid_o <= 1'b0;
    frame_o       <= ~f;
  endtask
endmodule
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking bench for the statistics block: APB master plus frame model.
// Assumes zero-wait APB slave and the register map of the package.
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import ssc_pkg::*;
;
  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        fvalid;
  ssc_frame_s  frame;
  int          errors = 0;
  int          comparisons = 0;
  int          cyc = 0;
  logic [31:0] rdat;
  logic        rerr;

  // 50 MHz core clock
  always #10 mclk_i = ~mclk_i;

  ssc_stat_top uut (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .frame_valid_i(fvalid), .frame_i(frame));

  ssc_frame_src src (.mclk_i(mclk_i), .frame_valid_o(fvalid), .frame_o(frame));

  task automatic report_and_stop();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer; data taken only at the edge where pready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    @(posedge mclk_i);
    while (pready !== 1'b1) @(posedge mclk_i);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Low word first, high byte straight after, so the shadow stays coherent
  task automatic rd40(input logic q, input int t, input int i, output logic [39:0] v);
    apb(1'b1, ADDR_SEL, {16'h0, q, 4'h0, t[2:0], 2'h0, i[5:0]});
    apb(1'b0, ADDR_LOW, 32'h0);
    v[31:0] = rdat;
    apb(1'b0, ADDR_HIGH, 32'h0);
    v[39:32] = rdat[7:0];
  endtask

  function automatic ssc_frame_s frm(input logic [5:0] b, input logic [2:0] o,
      input logic [11:0] v, input logic [1:0] dp, input ssc_colour_e pc, input ssc_cast_e c,
      input logic [13:0] n, input logic [2:0] p, input logic [2:0] pr, input logic ps,
      input logic dr);
    frm = '{b, o, v, dp, pc, c, n, p, pr, ps, dr};
  endfunction

  task automatic t_reset_map();
    apb(1'b0, ADDR_DP_MAP, 32'h0);
    chk("dp table reset", {24'h0, DP_MAP_RST}, rdat);
    apb(1'b0, 12'h0FC, 32'h0);
    chk("unmapped err", 1'b1, rerr);
    apb(1'b0, ADDR_SVC_CFG0, 32'h0);
    chk("mask reset", 32'h0, rdat);
  endtask

  task automatic t_colour_cast();
    logic [39:0] v;
    logic [39:0] ex [6];
    ex = '{0, 100, 0, 0, 1, 0};
    for (int t = 0; t < 6; t++) begin
      apb(1'b1, ADDR_SVC_CFG0 + 12'(4 * t), ((t < 3) ? 32'h100 : 32'h0) | (32'h1 << t));
    end
    src.send(frm(6'd5, 3'd2, 12'd0, 2'd1, COL_GREEN, CAST_MULTI, 14'd100, 0, 0, 0, 0));
    for (int t = 0; t < 6; t++) begin
      rd40(1'b0, t, 7, v);
      chk("service type", ex[t], v);
    end
    apb(1'b1, ADDR_GLOBAL, 32'h1);
    src.send(frm(6'd5, 3'd2, 12'd0, 2'd1, COL_GREEN, CAST_MULTI, 14'd100, 0, 0, 0, 0));
    rd40(1'b0, 0, 7, v);
    chk("policer colour", 40'd100, v);
    apb(1'b1, ADDR_DP_MAP, 32'h18);
    apb(1'b1, ADDR_GLOBAL, 32'h0);
    src.send(frm(6'd5, 3'd2, 12'd0, 2'd1, COL_GREEN, CAST_NONE, 14'd100, 0, 0, 0, 0));
    rd40(1'b0, 2, 7, v);
    chk("dp table red", 40'd100, v);
    // Precedence 2 now maps to yellow, cast-free so only colour counts
    src.send(frm(6'd5, 3'd2, 12'd0, 2'd2, COL_GREEN, CAST_NONE, 14'd50, 0, 0, 0, 0));
    rd40(1'b0, 1, 7, v);
    chk("dp table yellow", 40'd150, v);
  endtask

  task automatic t_vlan();
    logic [39:0] v;
    // Policer colour none: only the flood type may count
    apb(1'b1, ADDR_GLOBAL, 32'h3);
    src.send(frm(6'd5, 3'd2, 12'd40, 2'd3, COL_NONE, CAST_FLOOD, 14'd64, 0, 0, 0, 0));
    rd40(1'b0, 5, 40, v);
    chk("vid entry", 40'd1, v);
    rd40(1'b0, 0, 40, v);
    chk("no colour event", 40'd0, v);
    rd40(1'b0, 5, 7, v);
    chk("base entry", 40'd0, v);
    apb(1'b1, ADDR_GLOBAL, 32'h0);
  endtask

  task automatic t_write_wrap();
    logic [39:0] v;
    apb(1'b1, ADDR_SEL, 32'h9);
    apb(1'b1, ADDR_HIGH, 32'hFF);
    apb(1'b1, ADDR_LOW, 32'hFFFFFFF0);
    apb(1'b0, ADDR_LOW, 32'h0);
    chk("low word", 32'hFFFFFFF0, rdat);
    src.send(frm(6'd9, 3'd0, 12'd0, 2'd0, COL_NONE, CAST_UNI, 14'h20, 0, 0, 0, 0));
    apb(1'b0, ADDR_HIGH, 32'h0);
    chk("shadow high", 8'hFF, rdat[7:0]);
    rd40(1'b0, 0, 9, v);
    chk("wide wrap", 40'h10, v);
    apb(1'b1, ADDR_SEL, 32'h309);
    apb(1'b1, ADDR_LOW, 32'hFFFFFFFF);
    src.send(frm(6'd9, 3'd0, 12'd0, 2'd0, COL_NONE, CAST_UNI, 14'h20, 0, 0, 0, 0));
    rd40(1'b0, 3, 9, v);
    chk("narrow wrap", 40'h0, v);
    apb(1'b1, ADDR_GLOBAL, 32'h100);
    rd40(1'b0, 1, 7, v);
    chk("cleared", 40'h0, v);
  endtask

  task automatic t_queue();
    logic [39:0] v;
    apb(1'b1, ADDR_Q_CFG0, 32'h101);
    apb(1'b1, ADDR_Q_CFG0 + 12'h4, 32'h2);
    src.send(frm(0, 0, 0, 0, COL_NONE, CAST_NONE, 14'd60, 3'd2, 3'd3, 1'b1, 1'b0));
    src.send(frm(0, 0, 0, 0, COL_NONE, CAST_NONE, 14'd60, 3'd2, 3'd3, 1'b0, 1'b1));
    rd40(1'b1, 0, 19, v);
    chk("queue passed", 40'd60, v);
    rd40(1'b1, 1, 19, v);
    chk("queue dropped", 40'd1, v);
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_reset_map();
    apb(1'b1, ADDR_GLOBAL, 32'h100);
    t_colour_cast();
    t_vlan();
    t_write_wrap();
    t_queue();
    report_and_stop();
  end
endmodule
`default_nettype wire
